// File: verilog/limit_ram_pkg.sv
// shared constants for the limit memory serial front end
`default_nettype none
package limit_ram_pkg;
    // command mode codes, first bit always one
    localparam logic [3:0] MODE_WATCH = 4'h8;
    localparam logic [3:0] MODE_WR1   = 4'h9;
    localparam logic [3:0] MODE_RD1   = 4'hb;
    localparam logic [3:0] MODE_WRALL = 4'hd;
    localparam logic [3:0] MODE_RDALL = 4'hf;
    localparam int MODE_MSB = 3;

    // widths
    localparam int ADDR_W  = 4;
    localparam int LIMIT_W = 8;
    localparam int CFG_W   = 12;
    localparam int GROUP_W = 3;
    localparam int CNT_W   = 8;
    localparam int MAX_CH  = 8;

    // serial bit positions, counted from zero after chip select falls
    localparam logic [CNT_W-1:0] BIT_MODE_END    = 8'h04;
    localparam logic [CNT_W-1:0] BIT_ADDR_LAST   = 8'h07;
    localparam logic [CNT_W-1:0] BIT_ADDR_END    = 8'h08;
    localparam logic [CNT_W-1:0] BIT_WR1_LAST    = 8'h0f;
    localparam logic [CNT_W-1:0] BIT_CFG_LAST    = 8'h0f;
    localparam logic [CNT_W-1:0] BIT_RD1_START   = 8'h0a;
    localparam logic [CNT_W-1:0] BIT_RDALL_START = 8'h06;
    localparam logic [CNT_W-1:0] CNT_MAX         = 8'hff;
    localparam logic [2:0]       BYTE_LAST       = 3'h7;
    localparam logic [2:0]       BYTE_FIRST      = 3'h0;

    // address folding for the two-channel variant
    localparam logic [ADDR_W-1:0] ADDR_MASK_2CH  = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_MASK_FULL = 4'hf;

    // channel pair group layout
    localparam int GRP_DIFF    = 2;
    localparam int GRP_EN_ODD  = 1;
    localparam int GRP_EN_EVEN = 0;

    // timing, oscillator clock
    localparam int CLK_PERIOD_NS = 5;
    localparam int CMP_TIME_NS   = 2000;
    localparam int CMP_CYC = (CMP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LEAVE_2CH = 8;
    localparam int LEAVE_8CH = 32;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARM  = 2'b01,
        ST_RUN  = 2'b10,
        ST_FLAG = 2'b11
    } wd_state_t;
endpackage
`default_nettype wire

// File: verilog/sync_2ff.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // level in and out
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage;

    always_ff @(posedge clock) begin
        if (rst) begin
            stage <= '0;
            q     <= '0;
        end else begin
            stage <= d;
            q     <= stage;
        end
    end
endmodule
`default_nettype wire

// File: verilog/limit_mem.sv
// limit memory: written and read on the link clock, read by the monitor
`timescale 1ns/1ps
`default_nettype none
module limit_mem #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 8,
    parameter int AW    = 4
) (
    // link side
    input  wire logic             linkClk,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddrLink,
    output logic      [WIDTH-1:0] rdataLink,
    // monitor side
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [AW-1:0]    raddrMon,
    output logic      [WIDTH-1:0] rdataMon
);
    logic [WIDTH-1:0] cells [DEPTH];

    always_ff @(posedge linkClk) begin
        if (we) begin
            cells[waddr] <= wdata;
        end
    end

    always_ff @(posedge linkClk) begin
        rdataLink <= cells[raddrLink];
    end

    // monitor reads on every clock, whether chip select is high or low
    always_ff @(posedge clock) begin
        if (rst) begin
            rdataMon <= '0;
        end else begin
            rdataMon <= cells[raddrMon];
        end
    end
endmodule
`default_nettype wire

// File: verilog/limit_ram_serial_access.sv
// serial command front end: limit memory access and watchdog sequencing
// How it works
// - sixteen eight-bit limits, two-channel uses four
// - even address lower limit, odd upper
// - four-bit address, two-channel decodes two LSBs
// - mode 1001 writes one addressed limit
// - address MSB first, limit data LSB first
// - bits captured from first rising edge
// - mode 1101 writes all limits sequentially
// - mode 1011 reads one addressed limit
// - read one drives third edge after address
// - mode 1111 reads all limits in order
// - read all drives third edge after command
// - watchdog feeds lower, upper limits in turn
// - watchdog ends with twelve config bits, MSB first
// - three config bits per channel pair
// - differential pair uses lower channel limits
// - select rising after full command starts watchdog
// - quiet: interrupt high, output off, cross pins high
// - four-bit mode code, first bit one
// - shift on rising edge, host samples falling
// - short select high leaves watchdog
`timescale 1ns/1ps
`default_nettype none
module limit_ram_serial_access #(
    parameter int CHANNELS = 8
) (
    // oscillator clock and reset
    input  wire logic                                 clock,
    input  wire logic                                 rst,
    // serial link
    input  wire logic                                 sclk,
    input  wire logic                                 csN,
    input  wire logic                                 di,
    output logic                                      doOut,
    output logic                                      doOe,
    // comparison path
    input  wire logic                                 inputAbove,
    output logic [limit_ram_pkg::LIMIT_W-1:0]         limitValue,
    output logic [limit_ram_pkg::ADDR_W-1:0]          limitAddr,
    output logic [2:0]                                compareChan,
    output logic                                      compareDiff,
    output logic                                      compareActive,
    output logic [limit_ram_pkg::CFG_W-1:0]           chanConfig,
    // watchdog flags
    output logic                                      intN,
    output logic                                      lowerCrossN,
    output logic                                      upperCrossN
);
    localparam int NLIM = 2 * CHANNELS;
    localparam int TMR_W = $clog2(limit_ram_pkg::CMP_CYC);
    localparam int LEAVE_CYC = (CHANNELS == 2) ? limit_ram_pkg::LEAVE_2CH
                                               : limit_ram_pkg::LEAVE_8CH;
    localparam bit HAS_CROSS = (CHANNELS == 2);
    localparam logic [limit_ram_pkg::ADDR_W-1:0] ADDR_MASK =
        (CHANNELS == 2) ? limit_ram_pkg::ADDR_MASK_2CH : limit_ram_pkg::ADDR_MASK_FULL;
    localparam logic [limit_ram_pkg::ADDR_W-1:0] LIM_LAST =
        limit_ram_pkg::ADDR_W'(NLIM - 1);
    localparam logic [4:0] NLIM_C = 5'(NLIM);

    // link domain
    logic [limit_ram_pkg::CNT_W-1:0]   bitCnt;
    logic [3:0]                        mode;
    logic [limit_ram_pkg::ADDR_W-1:0]  addr;
    logic [limit_ram_pkg::LIMIT_W-1:0] dataSh;
    logic [limit_ram_pkg::LIMIT_W-1:0] inByte;
    logic [limit_ram_pkg::LIMIT_W-1:0] outSh;
    logic [limit_ram_pkg::LIMIT_W-1:0] rdData;
    logic [limit_ram_pkg::CFG_W-1:0]   cfgShift;
    logic [limit_ram_pkg::CNT_W-1:0]   wrOff;
    logic [limit_ram_pkg::CNT_W-1:0]   rdOff;
    logic [4:0]                        rdIdx;
    logic [limit_ram_pkg::ADDR_W-1:0]  memWaddr;
    logic [limit_ram_pkg::ADDR_W-1:0]  rdAddr;
    logic                              cmdValid;
    logic                              wdDone;
    logic                              memWe;
    logic                              wr1Hit;
    logic                              wrAllHit;
    logic                              load1;
    logic                              loadAll;
    logic                              loadOut;

    // monitor domain
    limit_ram_pkg::wd_state_t          state;
    logic                              csHighS;
    logic                              csLowS;
    logic                              wdDoneS;
    logic                              aboveS;
    logic                              csPrev;
    logic [5:0]                        highCnt;
    logic [limit_ram_pkg::ADDR_W-1:0]  limIdx;
    logic [limit_ram_pkg::ADDR_W-1:0]  nextIdx;
    logic [TMR_W-1:0]                  cmpTimer;
    logic [limit_ram_pkg::CFG_W-1:0]   cfgReg;
    logic [limit_ram_pkg::MAX_CH-1:0]  chanEn;
    logic [limit_ram_pkg::MAX_CH-1:0]  chanDiff;
    logic [2:0]                        limCh;
    logic                              limEn;
    logic                              cmpDone;
    logic                              crossed;
    logic                              lowFlag;
    logic                              highFlag;

    // frame bit counter, cleared by chip select itself since sclk stops
    always_ff @(posedge sclk or posedge csN or posedge rst) begin
        if (rst || csN) begin
            bitCnt <= '0;
        end else if (bitCnt != limit_ram_pkg::CNT_MAX) begin
            bitCnt <= bitCnt + 1'b1;
        end
    end

    always_ff @(posedge sclk) begin
        if (bitCnt < limit_ram_pkg::BIT_MODE_END) begin
            mode <= {mode[2:0], di};
        end
    end

    always_ff @(posedge sclk) begin
        if (bitCnt >= limit_ram_pkg::BIT_MODE_END && bitCnt < limit_ram_pkg::BIT_ADDR_END) begin
            addr <= {addr[limit_ram_pkg::ADDR_W-2:0], di};
        end
    end

    assign inByte = {di, dataSh[limit_ram_pkg::LIMIT_W-1:1]};
    always_ff @(posedge sclk) begin
        dataSh <= inByte;
    end

    always_ff @(posedge sclk) begin
        if (mode == limit_ram_pkg::MODE_WATCH && bitCnt >= limit_ram_pkg::BIT_MODE_END
            && bitCnt <= limit_ram_pkg::BIT_CFG_LAST) begin
            cfgShift <= {cfgShift[limit_ram_pkg::CFG_W-2:0], di};
        end
    end

    // survives chip select high so the monitor can see it
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            wdDone <= 1'b0;
        end else if (bitCnt == '0) begin
            wdDone <= 1'b0;
        end else if (cmdValid && mode == limit_ram_pkg::MODE_WATCH
                     && bitCnt == limit_ram_pkg::BIT_CFG_LAST) begin
            wdDone <= 1'b1;
        end
    end

    assign cmdValid = mode[limit_ram_pkg::MODE_MSB] && bitCnt >= limit_ram_pkg::BIT_MODE_END;
    assign wrOff = bitCnt - limit_ram_pkg::BIT_MODE_END;
    assign rdOff = bitCnt - limit_ram_pkg::BIT_RDALL_START;

    // whole bytes only: a byte cut short by chip select is never written
    assign wr1Hit = cmdValid && mode == limit_ram_pkg::MODE_WR1
                    && bitCnt == limit_ram_pkg::BIT_WR1_LAST;
    assign wrAllHit = cmdValid && mode == limit_ram_pkg::MODE_WRALL
                      && wrOff[2:0] == limit_ram_pkg::BYTE_LAST
                      && wrOff[7:3] < NLIM_C;
    assign memWe = wr1Hit || wrAllHit;
    assign memWaddr = wr1Hit ? (addr & ADDR_MASK) : wrOff[6:3];

    assign load1 = cmdValid && mode == limit_ram_pkg::MODE_RD1
                   && bitCnt == limit_ram_pkg::BIT_RD1_START;
    assign loadAll = cmdValid && mode == limit_ram_pkg::MODE_RDALL
                     && bitCnt >= limit_ram_pkg::BIT_RDALL_START
                     && rdOff[2:0] == limit_ram_pkg::BYTE_FIRST
                     && rdIdx < NLIM_C;
    assign loadOut = load1 || loadAll;
    assign rdAddr = (mode == limit_ram_pkg::MODE_RD1) ? (addr & ADDR_MASK) : rdIdx[3:0];

    always_ff @(posedge sclk) begin
        if (bitCnt == '0) begin
            rdIdx <= '0;
        end else if (loadAll) begin
            rdIdx <= rdIdx + 1'b1;
        end
    end

    // output changes on the rising edge, host samples on the falling one
    always_ff @(posedge sclk) begin
        if (loadOut) begin
            outSh <= rdData;
        end else begin
            outSh <= {1'b0, outSh[limit_ram_pkg::LIMIT_W-1:1]};
        end
    end
    assign doOut = outSh[0];

    always_ff @(posedge sclk or posedge csN or posedge rst) begin
        if (rst || csN) begin
            doOe <= 1'b0;
        end else if (loadOut) begin
            doOe <= 1'b1;
        end
    end

    limit_mem #(
        .DEPTH (1 << limit_ram_pkg::ADDR_W),
        .WIDTH (limit_ram_pkg::LIMIT_W),
        .AW    (limit_ram_pkg::ADDR_W)
    ) u_mem (
        .linkClk   (sclk),
        .we        (memWe),
        .waddr     (memWaddr),
        .wdata     (inByte),
        .raddrLink (rdAddr),
        .rdataLink (rdData),
        .clock     (clock),
        .rst       (rst),
        .raddrMon  (limIdx),
        .rdataMon  (limitValue)
    );

    sync_2ff #(
        .WIDTH (3)
    ) u_sync (
        .clock (clock),
        .rst   (rst),
        .d     ({!csN, wdDone, inputAbove}),
        .q     ({csLowS, wdDoneS, aboveS})
    );
    // select idles high, so reset must read it high: no false rising edge
    assign csHighS = !csLowS;

    // pair group 0 sits at the top of the field, sent first
    genvar c;
    generate
        for (c = 0; c < limit_ram_pkg::MAX_CH; c++) begin : g_chan
            if (c < CHANNELS) begin : g_used
                localparam int HI = limit_ram_pkg::CFG_W - 1 - limit_ram_pkg::GROUP_W * (c / 2);
                wire [limit_ram_pkg::GROUP_W-1:0] grp = cfgReg[HI -: limit_ram_pkg::GROUP_W];
                if (c % 2 == 0) begin : g_even
                    assign chanEn[c] = grp[limit_ram_pkg::GRP_EN_EVEN];
                end else begin : g_odd
                    assign chanEn[c] = grp[limit_ram_pkg::GRP_EN_ODD]
                                       && !grp[limit_ram_pkg::GRP_DIFF];
                end
                assign chanDiff[c] = grp[limit_ram_pkg::GRP_DIFF];
            end else begin : g_none
                assign chanEn[c]   = 1'b0;
                assign chanDiff[c] = 1'b0;
            end
        end
    endgenerate

    assign limCh   = limIdx[3:1];
    assign limEn   = chanEn[limCh];
    assign cmpDone = (cmpTimer == TMR_W'(limit_ram_pkg::CMP_CYC - 1));
    assign crossed = limIdx[0] ? aboveS : !aboveS;
    assign nextIdx = (limIdx == LIM_LAST) ? '0 : limIdx + 1'b1;

    always_ff @(posedge clock) begin
        if (rst) begin
            csPrev <= 1'b1;
        end else begin
            csPrev <= csHighS;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state    <= limit_ram_pkg::ST_IDLE;
            highCnt  <= '0;
            limIdx   <= '0;
            cmpTimer <= '0;
            cfgReg   <= '0;
            lowFlag  <= 1'b0;
            highFlag <= 1'b0;
        end else begin
            case (state)
                limit_ram_pkg::ST_IDLE: begin
                    lowFlag  <= 1'b0;
                    highFlag <= 1'b0;
                    if (csHighS && !csPrev && wdDoneS) begin
                        // link config is static once select is high
                        cfgReg  <= cfgShift;
                        highCnt <= '0;
                        state   <= limit_ram_pkg::ST_ARM;
                    end
                end
                limit_ram_pkg::ST_ARM: begin
                    if (!csHighS) begin
                        state <= limit_ram_pkg::ST_IDLE;
                    end else if (highCnt == 6'(LEAVE_CYC - 1)) begin
                        limIdx   <= '0;
                        cmpTimer <= '0;
                        state    <= limit_ram_pkg::ST_RUN;
                    end else begin
                        highCnt <= highCnt + 1'b1;
                    end
                end
                limit_ram_pkg::ST_RUN: begin
                    if (!csHighS) begin
                        state <= limit_ram_pkg::ST_IDLE;
                    end else if (!limEn) begin
                        limIdx   <= nextIdx;
                        cmpTimer <= '0;
                    end else if (cmpDone) begin
                        cmpTimer <= '0;
                        if (crossed) begin
                            lowFlag  <= !limIdx[0];
                            highFlag <= limIdx[0];
                            state    <= limit_ram_pkg::ST_FLAG;
                        end else begin
                            limIdx <= nextIdx;
                        end
                    end else begin
                        cmpTimer <= cmpTimer + 1'b1;
                    end
                end
                limit_ram_pkg::ST_FLAG: begin
                    if (!csHighS) begin
                        state <= limit_ram_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= limit_ram_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            intN        <= 1'b1;
            lowerCrossN <= 1'b1;
            upperCrossN <= 1'b1;
        end else begin
            intN        <= !(state == limit_ram_pkg::ST_FLAG);
            lowerCrossN <= !(HAS_CROSS && state == limit_ram_pkg::ST_FLAG && lowFlag);
            upperCrossN <= !(HAS_CROSS && state == limit_ram_pkg::ST_FLAG && highFlag);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            limitAddr     <= '0;
            compareChan   <= '0;
            compareDiff   <= 1'b0;
            compareActive <= 1'b0;
            chanConfig    <= '0;
        end else begin
            limitAddr     <= limIdx;
            compareChan   <= limCh;
            compareDiff   <= chanDiff[limCh] && !limCh[0];
            compareActive <= (state == limit_ram_pkg::ST_RUN) && limEn;
            chanConfig    <= cfgReg;
        end
    end

    // checks on the link
    chk_wr1_commit: assert property (@(posedge sclk) disable iff (csN || rst)
        (cmdValid && mode == limit_ram_pkg::MODE_WR1 && bitCnt == limit_ram_pkg::BIT_WR1_LAST)
        |-> memWe && memWaddr == (addr & ADDR_MASK))
        else $error("single write not committed");
    chk_rd1_start: assert property (@(posedge sclk) disable iff (csN || rst)
        (cmdValid && mode == limit_ram_pkg::MODE_RD1 && bitCnt == limit_ram_pkg::BIT_ADDR_END)
        |-> ##2 !doOe ##1 doOe)
        else $error("read one starts on wrong edge");
    chk_rdall_start: assert property (@(posedge sclk) disable iff (csN || rst)
        (cmdValid && mode == limit_ram_pkg::MODE_RDALL && bitCnt == limit_ram_pkg::BIT_MODE_END)
        |-> ##2 !doOe ##1 doOe)
        else $error("read all starts on wrong edge");
    chk_addr_fold: assert property (@(posedge sclk) disable iff (csN || rst)
        memWe |-> (memWaddr & ~ADDR_MASK) == '0)
        else $error("write outside decoded range");
    chk_whole_byte: assert property (@(posedge sclk) disable iff (csN || rst)
        memWe |-> (bitCnt == limit_ram_pkg::BIT_WR1_LAST
                   || wrOff[2:0] == limit_ram_pkg::BYTE_LAST))
        else $error("write before byte complete");
    chk_mode_lead: assert property (@(posedge sclk) disable iff (csN || rst)
        (bitCnt >= limit_ram_pkg::BIT_MODE_END && !mode[limit_ram_pkg::MODE_MSB])
        |-> !memWe && !loadOut)
        else $error("acted on bad mode code");
    chk_lsb_order: assert property (@(posedge sclk) disable iff (csN || rst)
        loadOut |=> (doOut == $past(rdData[0])) ##1 (doOut == $past(rdData[1], 2)))
        else $error("limit not sent lsb first");

    // checks on the monitor
    chk_short_high: assert property (@(posedge clock) disable iff (rst)
        (state == limit_ram_pkg::ST_ARM && !csHighS) |=> state == limit_ram_pkg::ST_IDLE)
        else $error("short select high kept watchdog");
    chk_arm_run: assert property (@(posedge clock) disable iff (rst)
        (state == limit_ram_pkg::ST_IDLE && csHighS && !csPrev && wdDoneS)
        |=> state == limit_ram_pkg::ST_ARM)
        else $error("watchdog not armed");
    chk_hold_run: assert property (@(posedge clock) disable iff (rst)
        (state == limit_ram_pkg::ST_ARM && csHighS && highCnt == 6'(LEAVE_CYC - 1))
        |=> state == limit_ram_pkg::ST_RUN)
        else $error("watchdog not running after hold");
    chk_int_quiet: assert property (@(posedge clock) disable iff (rst)
        (state != limit_ram_pkg::ST_FLAG) |=> intN && lowerCrossN && upperCrossN)
        else $error("flag pin low while quiet");
    chk_lower_cross: assert property (@(posedge clock) disable iff (rst)
        (HAS_CROSS && state == limit_ram_pkg::ST_RUN && csHighS && limEn && cmpDone
         && !limIdx[0] && !aboveS) |=> ##1 (!intN && !lowerCrossN && upperCrossN))
        else $error("lower crossing not flagged");

    cov_write_one: cover property (@(posedge sclk) wr1Hit);
    cov_read_all: cover property (@(posedge sclk) loadAll && rdIdx == 5'h01);
    cov_run: cover property (@(posedge clock) state == limit_ram_pkg::ST_RUN);
    cov_flag: cover property (@(posedge clock) !intN);
endmodule
`default_nettype wire

// File: verification/serial_host.sv
// host model for the serial link
`timescale 1ns/1ps
`default_nettype none
module serial_host (
    // link to the device
    output logic      sclk,
    output logic      csN,
    output logic      di,
    input  wire logic doOut,
    input  wire logic doOe
);
    // clock stands still outside frames
    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        di = 1'b0;
    end
    // bit k of tx goes out at the (k+1)th rising edge
    task automatic xfer(input logic [159:0] tx, input int n, output logic [159:0] rx);
        rx = '0;
        #20 csN = 1'b0;
        #7;
        for (int k = 0; k < n; k++) begin
            di = tx[k];
            #3 sclk = 1'b1;
            #6 sclk = 1'b0;
            rx[k] = doOe & doOut;
            #3;
        end
        csN = 1'b1;
        // released line must not keep its last value
        di = ~di;
    endtask
endmodule
`default_nettype wire

// File: verification/limit_ram_serial_access_tb.sv
// self-checking bench for the limit memory serial front end
`timescale 1ns/1ps
`default_nettype none
module limit_ram_serial_access_tb;
    logic         clock, rst, inputAbove, sclk, csN, di, doOut, doOe;
    logic         intN, lowerCrossN, upperCrossN, compareDiff, compareActive;
    logic         intN2, lowerCrossN2, upperCrossN2;
    logic [7:0]   limitValue, limitValue2;
    logic [3:0]   limitAddr;
    logic [2:0]   compareChan;
    logic [11:0]  chanConfig;
    logic [159:0] tx, rx;
    logic [7:0]   mem [16];
    // rows: address, then the limit written and read back
    logic [11:0]  rows [4] = '{12'h0a5, 12'hf3c, 12'h501, 12'ha80};
    int           err_total = 0, check_count = 0, cycles = 0;

    limit_ram_serial_access #(.CHANNELS(8)) i_limit_ram_serial_access (.clock, .rst,
        .sclk, .csN, .di, .doOut, .doOe, .inputAbove, .limitValue, .limitAddr,
        .compareChan, .compareDiff, .compareActive, .chanConfig, .intN,
        .lowerCrossN, .upperCrossN);
    serial_host i_serial_host (.sclk, .csN, .di, .doOut, .doOe);
    // two-channel variant on the same link: folded addresses and cross pins
    limit_ram_serial_access #(.CHANNELS(2)) i_limit_ram_serial_access_2ch (.clock, .rst,
        .sclk, .csN, .di, .doOut(), .doOe(), .inputAbove, .limitValue(limitValue2),
        .limitAddr(), .compareChan(), .compareDiff(), .compareActive(), .chanConfig(),
        .intN(intN2), .lowerCrossN(lowerCrossN2), .upperCrossN(upperCrossN2));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic xf(input logic [159:0] t, input int n);
        i_serial_host.xfer(t, n, rx);
    endtask
    // address goes out msb first, so reverse it into the lsb-first vector
    function automatic logic [3:0] rv(input logic [3:0] a);
        return {a[0], a[1], a[2], a[3]};
    endfunction

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            report_and_stop();
        end
    end

    initial begin
        rst = 1'b1;
        inputAbove = 1'b1;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        check({intN, lowerCrossN, upperCrossN, doOe, compareActive, intN2, lowerCrossN2,
               upperCrossN2}, 16'h00e7);
        foreach (rows[i]) begin
            xf({rows[i][7:0], rv(rows[i][11:8]), 4'h9}, 16);
            xf({rv(rows[i][11:8]), 4'hd}, 18);
            check(rx[17:10], rows[i][7:0]);
        end
        tx = 160'hb;
        for (int i = 0; i < 16; i++) begin
            mem[i] = 8'(i * 17 + 7);
            tx[4 + 8 * i +: 8] = mem[i];
        end
        xf(tx, 132);
        xf(160'hf, 134);
        for (int i = 0; i < 16; i++) check(rx[6 + 8 * i +: 8], mem[i]);
        // cut-short byte, then a frame whose first mode bit is zero
        xf({5'h15, rv(4'h3), 4'h9}, 13);
        xf({8'h5a, rv(4'h2), 4'h8}, 16);
        for (int a = 2; a < 4; a++) begin
            xf({rv(4'(a)), 4'hd}, 18);
            check(rx[17:10], mem[a]);
        end
        // watchdog, pair 0 differential so only channel 0 limits; config sent msb first
        xf({12'h005, 4'h1}, 16);
        repeat (100) @(negedge clock);
        check(chanConfig, 12'ha00);
        check({compareActive, limitAddr, limitValue}, {1'b1, 4'h0, mem[0]});
        check({compareChan, compareDiff}, 4'h1);
        check({intN, doOe, upperCrossN}, 3'h5);
        repeat (500) @(negedge clock);
        check({limitAddr, limitValue}, {4'h1, mem[1]});
        check({compareChan, compareDiff}, 4'h1);
        check({intN2, lowerCrossN2, upperCrossN2, limitValue2}, {3'h7, mem[1]});
        repeat (400) @(negedge clock);
        check({intN, upperCrossN}, 2'h1);
        check({intN2, lowerCrossN2, upperCrossN2}, 3'h2);
        xf({rv(4'h0), 4'hd}, 18);
        check({intN, rx[17:10]}, {1'b1, mem[0]});
        report_and_stop();
    end
endmodule
`default_nettype wire
